// [src/logic_cell_register_control.sv]
// Storage register of one logic cell with its control logic
//
// Summary of operation
// R1 - Counter mode: selector loads data on sync load
// R2 - Counter mode: sync clear forces register to zero
// R3 - Sync clear wins over sync load
// R4 - Counter mode: sync clear/load override the cascade input
// R5 - Arithmetic mode: registered outputs only; comb path takes lut_in past the cascade
// R6 - Native asynchronous clear zeroes register immediately
// R7 - Clear and preset come from cluster-wide signals
// R8 - Chip-wide clear resets every register except the output flops
// R9 - Chip-wide clear overrides all other controls
// R10 - Inverted-preset register reads preset under chip clear
// R11 - Preset-plus-load emulation undefined after chip clear
// R12 - Otherwise capture normal next-state value each edge
`timescale 1ns/1ns
module logic_cell_register_control
  import cell_reg_pkg::*;
(
  input  wire logic                    clock,
  input  wire logic                    arst_n,
  input  wire logic                    chip_wide_clear_pin_n,
  input  wire logic [1:0]              mode,
  input  wire logic                    preset_by_inversion,
  input  wire cell_reg_pkg::cluster_ctrl_t cluster_ctrl,
  input  wire logic                    lut_in,
  input  wire logic                    carry_in,
  input  wire logic                    cascade_in,
  input  wire logic                    cascade_en,
  input  wire logic                    load_data,
  output logic                         reg_out,
  output logic                         comb_out,
  output logic                         carry_out,
  output logic                         state_undefined
);
  import cell_reg_pkg::*;

  // Stored bit
  logic stored_ff;
  logic nxt_stored;

  // Arithmetic and carry path
  logic comb_ff;
  logic nxt_comb;
  logic carry_ff;
  logic nxt_carry;

  // Preset-with-load emulation tracking
  logic undef_ff;
  logic nxt_undef;

  // Output stage
  logic nxt_reg_out;
  logic nxt_comb_out;
  logic nxt_carry_out;
  logic nxt_state_undefined;

  // Mode decode
  logic is_counter;
  logic is_arith;

  // Resets and cluster-wide controls
  logic core_rst_n;
  logic cell_aclr;
  logic cell_apre;
  logic sync_clear;
  logic sync_load;

  // Data path
  logic cascaded;
  logic cur_value;
  logic count_val;
  logic lut_val;
  logic load_sel;
  logic clr_gate;
  logic ctr_next;
  logic raw_next;
  logic raw_q;

  assign is_counter = (mode == MODE_COUNTER);
  assign is_arith   = (mode == MODE_ARITH);

  // Chip clear folded into the async reset so it beats everything
  assign core_rst_n = arst_n & chip_wide_clear_pin_n; // see R8 see R9

  // Cluster-wide lines only; a cell has no private clear or preset
  assign cell_aclr  = cluster_ctrl.cluster_aclr; // see R7 see R6
  assign cell_apre  = cluster_ctrl.cluster_apre; // see R7
  assign sync_clear = cluster_ctrl.sync_clear;
  assign sync_load  = cluster_ctrl.sync_load;

  // Cascade combines by AND with the table result
  assign cascaded   = cascade_en ? (lut_in & cascade_in) : lut_in;

  // Logical value; raw bit is inverted under preset emulation
  assign cur_value  = stored_ff ^ preset_by_inversion;
  assign count_val  = cascaded ^ cur_value ^ carry_in; // see R12
  assign lut_val    = is_counter ? count_val : cascaded; // see R12

  // Selector ahead of the clear gate, so clear beats load
  assign load_sel   = sync_load ? load_data : lut_val; // see R1 see R4
  assign clr_gate   = is_counter & sync_clear; // see R2 see R3 see R4
  assign ctr_next   = clr_gate ? RESET_VALUE : (is_counter ? load_sel : lut_val);

  // Inverted storage: a cleared raw bit reads as preset
  assign raw_next   = ctr_next ^ preset_by_inversion;
  assign raw_q      = stored_ff ^ preset_by_inversion; // see R10

  assign nxt_stored = raw_next;
  assign nxt_comb   = is_arith ? lut_in : cascaded; // see R5
  assign nxt_carry  = lut_in & carry_in;
  assign nxt_undef  = undef_ff & ~sync_load & cell_apre; // see R11

  // Output stage re-times every value by one flop
  assign nxt_reg_out         = raw_q; // see R5 see R10
  assign nxt_comb_out        = comb_ff;
  assign nxt_carry_out       = carry_ff;
  assign nxt_state_undefined = undef_ff & cell_apre; // see R11

  // Stored bit: chip clear and cluster clear act without the clock
  always_ff @(posedge clock or negedge core_rst_n or posedge cell_aclr)
  begin
    if (!core_rst_n)
    begin
      stored_ff <= RESET_VALUE; // see R8 see R9
    end
    else if (cell_aclr)
    begin
      stored_ff <= RESET_VALUE; // see R6
    end
    else
    begin
      stored_ff <= nxt_stored; // see R12
    end
  end

  always_ff @(posedge clock or negedge core_rst_n)
  begin
    if (!core_rst_n)
    begin
      comb_ff <= RESET_VALUE;
    end
    else
    begin
      comb_ff <= nxt_comb;
    end
  end

  always_ff @(posedge clock or negedge core_rst_n)
  begin
    if (!core_rst_n)
    begin
      carry_ff <= RESET_VALUE;
    end
    else
    begin
      carry_ff <= nxt_carry;
    end
  end

  // Undefined until a sync load or a low cluster_apre; a chip clear makes it so again
  always_ff @(posedge clock or negedge core_rst_n)
  begin
    if (!core_rst_n)
    begin
      undef_ff <= 1'h1; // see R11
    end
    else
    begin
      undef_ff <= nxt_undef;
    end
  end

  // Output flops reset only on the system reset, not on chip clear
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      reg_out <= RESET_VALUE;
    end
    else
    begin
      reg_out <= nxt_reg_out;
    end
  end

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      comb_out <= RESET_VALUE;
    end
    else
    begin
      comb_out <= nxt_comb_out;
    end
  end

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      carry_out <= RESET_VALUE;
    end
    else
    begin
      carry_out <= nxt_carry_out;
    end
  end

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_undefined <= 1'h1;
    end
    else
    begin
      state_undefined <= nxt_state_undefined;
    end
  end

endmodule

// [src/cell_reg_pkg.sv]
// Constants and types for the logic cell register
package cell_reg_pkg;
  localparam int       DATA_W      = 1;
  localparam logic     RESET_VALUE = 1'h0;
  localparam logic     PRESET_VALUE = 1'h1;
  localparam logic [1:0] MODE_NORMAL  = 2'h0;
  localparam logic [1:0] MODE_COUNTER = 2'h1;
  localparam logic [1:0] MODE_ARITH   = 2'h2;

  typedef struct packed {
    logic sync_clear;
    logic sync_load;
    logic cluster_aclr;
    logic cluster_apre;
  } cluster_ctrl_t;
endpackage

// [verification/cell_reg_sva.sv]
// Port checker for the cell register
`timescale 1ns/1ns
module cell_reg_sva
  import cell_reg_pkg::*;
(
  input wire logic clock,
  input wire logic arst_n,
  input wire logic chip_wide_clear_pin_n,
  input wire logic [1:0] mode,
  input wire logic preset_by_inversion,
  input wire cluster_ctrl_t cluster_ctrl,
  input wire logic load_data,
  input wire logic lut_in,
  input wire logic carry_in,
  input wire logic cascade_in,
  input wire logic cascade_en,
  input wire logic reg_out,
  input wire logic comb_out,
  input wire logic carry_out,
  input wire logic state_undefined
);
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);
  wire q = chip_wide_clear_pin_n && !cluster_ctrl.cluster_aclr, k = q && mode == MODE_COUNTER;
  wire s = cluster_ctrl.sync_clear, l = cluster_ctrl.sync_load, p = preset_by_inversion;
  wire c = chip_wide_clear_pin_n, cas = cascade_en ? lut_in & cascade_in : lut_in;
  property p_sc; k && s ##1 q |-> ##1 !reg_out; endproperty
  a_sc: assert property (p_sc) else $error("clear lost");
  property p_nx;
    k && !s && !l ##1 q |->
      ##1 reg_out == ($past(cas, 2) ^ $past(reg_out) ^ $past(carry_in, 2));
  endproperty
  a_nx: assert property (p_nx) else $error("count lost");
  property p_ar; c && mode == MODE_ARITH ##1 c |-> ##1 comb_out == $past(lut_in, 2); endproperty
  a_ar: assert property (p_ar) else $error("arith path lost");
  property p_cc;
    !c |-> ##1 !comb_out && !carry_out && state_undefined == $past(cluster_ctrl.cluster_apre);
  endproperty
  a_cc: assert property (p_cc) else $error("chip clear lost");
  property p_ld; k && l && !s ##1 q |-> ##1 reg_out == $past(load_data, 2); endproperty
  a_ld: assert property (p_ld) else $error("load lost");
  property p_aq; !q |-> ##1 reg_out == p; endproperty
  a_aq: assert property (p_aq) else $error("clear ignored");
  c_sl: cover property (k && s && l);
  c_ld: cover property (k && l ##1 q);
  c_aq: cover property (!q && l);
endmodule
bind logic_cell_register_control cell_reg_sva u_sva (.*);

// [verification/logic_cell_register_control_test.sv]
// Random bench for the cell register
`timescale 1ns/1ns
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin error_cnt++; \
  $display("[ERR] %0t output mismatch", $time); end end
module logic_cell_register_control_test;
  logic        clock = 0, arst_n = 0, pbi = 0, ro, co, ko, uo;
  logic [31:0] x = 32'h455C, v = 0;
  int          cyc = 0, error_cnt = 0, n_checks = 0;
  bit          r = 0, cf = 0, ca = 0, uf = 1, cas = 0, nx = 0;
  bit          e_ro = 0, e_co = 0, e_ca = 0, e_su = 1;
  wire         chip = ~|v[12:11], aclr = &v[7:5], cnt = v[1], arith = v[2] & ~v[1];
  wire         sc = v[3], sl = v[4], apre = v[8], ld = v[9], lut = v[13], cin = v[14];
  always #50 clock = ~clock;
  logic_cell_register_control dut (.clock, .arst_n, .chip_wide_clear_pin_n(|v[12:11]),
    .mode({arith, cnt}), .preset_by_inversion(pbi), .load_data(ld),
    .cluster_ctrl({sc, sl, aclr, apre}), .lut_in(lut), .carry_in(cin),
    .cascade_in(v[15]), .cascade_en(v[16]), .reg_out(ro), .comb_out(co), .carry_out(ko),
    .state_undefined(uo));
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  task automatic give_verdict;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge clock)
  begin
    cyc++;
    arst_n <= cyc % 3000 > 3;
    pbi <= cyc > 3000;
    if (arst_n)
    begin
      `CHK(ro, e_ro)
      `CHK(co, e_co)
      `CHK(ko, e_ca)
      `CHK(uo, e_su)
    end
    if (!arst_n || chip)
    begin
      r = 0;
      cf = 0;
      ca = 0;
      uf = 1;
    end
    else if (aclr)
      r = 0;
    e_ro = arst_n ? r ^ pbi : 0;
    e_co = arst_n ? cf : 0;
    e_ca = arst_n ? ca : 0;
    e_su = arst_n ? uf & apre : 1;
    if (arst_n && !chip)
    begin
      cas = v[16] ? lut & v[15] : lut;
      nx = cnt ? (sc ? 1'b0 : sl ? ld : cas ^ r ^ pbi ^ cin) : cas;
      if (!aclr) r = nx ^ pbi;
      cf = arith ? lut : cas;
      ca = lut & cin;
      uf = uf & ~sl & apre;
    end
    x = xorshift(x);
    v <= x;
    if (cyc % 3000 == 0) $display("test %0d end", cyc / 3000);
    if (cyc == 6000) give_verdict;
  end
endmodule
